// ### rtl/pic_map.svh
// Register map, field positions, vectors and timing counts of the interrupt controller
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH
`define PIC_ADDR_ENABLE_LO   8'hA8
`define PIC_ADDR_PRIO_LO     8'hA9
`define PIC_ADDR_ENABLE_HI   8'hB8
`define PIC_ADDR_PRIO_HI     8'hB9
`define PIC_ADDR_REQ_FLAGS   8'hC0
`define PIC_ADDR_EVT_STATUS  8'hC8
`define PIC_ADDR_EVT_MASK    8'hC9
`define PIC_RESET_BYTE       8'h00
`define PIC_MASK_ENABLE_LO   8'hBF
`define PIC_MASK_ENABLE_HI   8'hB3
`define PIC_MASK_PRIO        8'h3F
`define PIC_MASK_REQ_FLAGS   8'hF3
`define PIC_MASK_EVT         8'h03
`define PIC_HWCLR_REQ_FLAGS  8'h32
`define PIC_BIT_GLOBAL_EN    7
`define PIC_BIT_TMR2_EN      5
`define PIC_BIT_SER0_EN      4
`define PIC_BIT_TMR1_EN      3
`define PIC_BIT_EXT1_EN      2
`define PIC_BIT_TMR0_EN      1
`define PIC_BIT_EXT0_EN      0
`define PIC_BIT_RELOAD_EN    7
`define PIC_BIT_TWI_EN       5
`define PIC_BIT_LVI_EN       4
`define PIC_BIT_SPI_EN       1
`define PIC_BIT_PWM_EN       0
`define PIC_BIT_T2_RELOAD    7
`define PIC_BIT_T2_OVF       6
`define PIC_BIT_TWI_FLAG     5
`define PIC_BIT_LVI_FLAG     4
`define PIC_BIT_SPI_FLAG     1
`define PIC_BIT_PWM_FLAG     0
`define PIC_EVT_TAKEN        0
`define PIC_EVT_RETURN       1
`define PIC_VEC_EXT0         16'h0003
`define PIC_VEC_PWM          16'h0043
`define PIC_VEC_TMR0         16'h000B
`define PIC_VEC_SPI          16'h004B
`define PIC_VEC_EXT1         16'h0013
`define PIC_VEC_TMR1         16'h001B
`define PIC_VEC_SER0         16'h0023
`define PIC_VEC_LVI          16'h0063
`define PIC_VEC_TMR2         16'h002B
`define PIC_VEC_TWI          16'h006B
`define PIC_NUM_SOURCES      10
`define PIC_NUM_LEVELS       4
`define PIC_FORCED_LONG_CALL_CYCLES     6
`endif

// ### rtl/pic_pkg.sv
// Types shared by the interrupt controller and its users
package pic_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pic_bus_t;
    typedef enum logic [0:0] {
        PIC_IDLE = 1'b0,
        PIC_CALL = 1'b1
    } pic_state_t;
endpackage

// ### rtl/pic_ctrl.sv
// Prioritized interrupt controller with ten sources and four levels
`timescale 1ns/1ns
`default_nettype none
`include "pic_map.svh"
module pic_ctrl #(
    parameter int unsigned CALL_CYCLES = `PIC_FORCED_LONG_CALL_CYCLES
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset,
    // Register bus
    input  wire pic_pkg::pic_bus_t i_bus,
    output logic [7:0]            o_rdata,
    // Flags held inside peripherals
    input  wire logic             i_ext_pin0_flag,
    input  wire logic             i_tmr0_overflow_flag,
    input  wire logic             i_ext_pin1_flag,
    input  wire logic             i_tmr1_overflow_flag,
    input  wire logic             i_serial0_rx_flag,
    input  wire logic             i_serial0_tx_flag,
    // One-cycle events that set the request register
    input  wire logic             i_tmr2_overflow_evt,
    input  wire logic             i_tmr2_reload_evt,
    input  wire logic             i_twowire_evt,
    input  wire logic             i_lowvolt_evt,
    input  wire logic             i_spi_evt,
    input  wire logic             i_pwm_evt,
    // Core handshake
    input  wire logic             i_instr_end,
    input  wire logic             i_return_from_interrupt,
    output logic                  o_forced_long_call,
    output logic [15:0]           o_vector,
    output logic [1:0]            o_level,
    output logic                  o_vector_taken,
    output logic [9:0]            o_src_ack,
    // Interrupt to the host
    output logic                  o_irq
);
    import pic_pkg::*;

    localparam int NSRC = `PIC_NUM_SOURCES;
    localparam int NLVL = `PIC_NUM_LEVELS;
    // Source index follows the polling order
    localparam logic [15:0] VEC [NSRC] = '{`PIC_VEC_EXT0, `PIC_VEC_PWM, `PIC_VEC_TMR0, `PIC_VEC_SPI,
        `PIC_VEC_EXT1, `PIC_VEC_TMR1, `PIC_VEC_SER0, `PIC_VEC_LVI, `PIC_VEC_TMR2, `PIC_VEC_TWI};
    localparam int GRP [NSRC] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5};

    logic [7:0]      enable_lo_q;
    logic [7:0]      enable_hi_q;
    logic [7:0]      prio_lo_q;
    logic [7:0]      prio_hi_q;
    logic [7:0]      req_flags_q;
    logic [7:0]      req_flags_d;
    logic [7:0]      evt_status_q;
    logic [7:0]      evt_mask_q;
    logic [NSRC-1:0] sample_q;
    logic [NSRC-1:0] sample_d;
    logic [NSRC-1:0] src_en;
    logic [NSRC-1:0] pending;
    logic [1:0]      src_lvl [NSRC];
    logic [NLVL-1:0] in_service_q;
    logic [NLVL-1:0] ret_clear;
    logic [1:0]      cur_lvl;
    logic            win_ok;
    logic [3:0]      win_src;
    logic [1:0]      win_lvl;
    logic            start;
    logic            last_call;
    logic            ack_next;
    logic [3:0]      src_q;
    logic [2:0]      cnt_q;
    pic_state_t      state_q;
    logic            wr_en;
    logic [7:0]      evt_set;

    assign wr_en = i_bus.wr;

    // Enable, priority and event mask registers
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            enable_lo_q <= `PIC_RESET_BYTE;
            enable_hi_q <= `PIC_RESET_BYTE;
            prio_lo_q   <= `PIC_RESET_BYTE;
            prio_hi_q   <= `PIC_RESET_BYTE;
            evt_mask_q  <= `PIC_RESET_BYTE;
        end else if (wr_en) begin
            case (i_bus.addr)
                `PIC_ADDR_ENABLE_LO:  enable_lo_q <= i_bus.wdata & `PIC_MASK_ENABLE_LO;
                `PIC_ADDR_ENABLE_HI:  enable_hi_q <= i_bus.wdata & `PIC_MASK_ENABLE_HI;
                `PIC_ADDR_PRIO_LO:    prio_lo_q   <= i_bus.wdata & `PIC_MASK_PRIO;
                `PIC_ADDR_PRIO_HI:    prio_hi_q   <= i_bus.wdata & `PIC_MASK_PRIO;
                `PIC_ADDR_EVT_MASK:   evt_mask_q  <= i_bus.wdata & `PIC_MASK_EVT;
                default: ;
            endcase
        end
    end

    // Request register: software write, hardware clear on vectoring, then events win
    always_comb begin
        req_flags_d = req_flags_q;
        if (wr_en && i_bus.addr == `PIC_ADDR_REQ_FLAGS) begin
            req_flags_d = i_bus.wdata & `PIC_MASK_REQ_FLAGS;
        end
        // Timer-2 and PWM flags stay set through vectoring
        if (last_call && (src_q == 4'h3 || src_q == 4'h7 || src_q == 4'h9)) begin
            req_flags_d = req_flags_d & ~(`PIC_HWCLR_REQ_FLAGS & (
                (src_q == 4'h3) ? (8'h01 << `PIC_BIT_SPI_FLAG) :
                (src_q == 4'h7) ? (8'h01 << `PIC_BIT_LVI_FLAG) : (8'h01 << `PIC_BIT_TWI_FLAG)));
        end
        req_flags_d[`PIC_BIT_T2_RELOAD] = req_flags_d[`PIC_BIT_T2_RELOAD] | i_tmr2_reload_evt;
        req_flags_d[`PIC_BIT_T2_OVF]    = req_flags_d[`PIC_BIT_T2_OVF] | i_tmr2_overflow_evt;
        req_flags_d[`PIC_BIT_TWI_FLAG]  = req_flags_d[`PIC_BIT_TWI_FLAG] | i_twowire_evt;
        req_flags_d[`PIC_BIT_LVI_FLAG]  = req_flags_d[`PIC_BIT_LVI_FLAG] | i_lowvolt_evt;
        req_flags_d[`PIC_BIT_SPI_FLAG]  = req_flags_d[`PIC_BIT_SPI_FLAG] | i_spi_evt;
        req_flags_d[`PIC_BIT_PWM_FLAG]  = req_flags_d[`PIC_BIT_PWM_FLAG] | i_pwm_evt;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            req_flags_q <= `PIC_RESET_BYTE;
        end else begin
            req_flags_q <= req_flags_d;
        end
    end

    // Request sample per machine cycle, in polling order except serial0 at 7 and low-voltage at 6
    assign sample_d = {
        req_flags_q[`PIC_BIT_TWI_FLAG],
        req_flags_q[`PIC_BIT_T2_OVF] | (req_flags_q[`PIC_BIT_T2_RELOAD] & enable_hi_q[`PIC_BIT_RELOAD_EN]),
        i_serial0_rx_flag | i_serial0_tx_flag,
        req_flags_q[`PIC_BIT_LVI_FLAG],
        i_tmr1_overflow_flag,
        i_ext_pin1_flag,
        req_flags_q[`PIC_BIT_SPI_FLAG],
        i_tmr0_overflow_flag,
        req_flags_q[`PIC_BIT_PWM_FLAG],
        i_ext_pin0_flag};
    // Reorder: index 6 is serial0 and 7 is low-voltage
    logic [NSRC-1:0] sample_ord;
    assign sample_ord = {sample_d[9:8], sample_d[6], sample_d[7], sample_d[5:0]};

    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sample_q <= '0;
        end else begin
            sample_q <= sample_ord;
        end
    end

    // Per-source enables gated by the global enable
    assign src_en = {enable_hi_q[`PIC_BIT_TWI_EN], enable_lo_q[`PIC_BIT_TMR2_EN], enable_hi_q[`PIC_BIT_LVI_EN],
        enable_lo_q[`PIC_BIT_SER0_EN], enable_lo_q[`PIC_BIT_TMR1_EN], enable_lo_q[`PIC_BIT_EXT1_EN],
        enable_hi_q[`PIC_BIT_SPI_EN], enable_lo_q[`PIC_BIT_TMR0_EN], enable_hi_q[`PIC_BIT_PWM_EN],
        enable_lo_q[`PIC_BIT_EXT0_EN]};
    assign pending = sample_q & src_en & {NSRC{enable_lo_q[`PIC_BIT_GLOBAL_EN]}};

    // Group level from the two priority registers
    for (genvar g = 0; g < NSRC; g++) begin : g_lvl
        assign src_lvl[g] = {prio_hi_q[GRP[g]], prio_lo_q[GRP[g]]};
    end

    // Highest level wins, first in polling order breaks a tie
    always_comb begin
        win_ok  = 1'b0;
        win_src = 4'h0;
        win_lvl = 2'h0;
        for (int i = 0; i < NSRC; i++) begin
            if (pending[i] && (!win_ok || src_lvl[i] > win_lvl)) begin
                win_ok  = 1'b1;
                win_src = 4'(i);
                win_lvl = src_lvl[i];
            end
        end
    end

    // Level now in service and the marker a return clears
    always_comb begin
        cur_lvl   = 2'h0;
        ret_clear = '0;
        for (int l = 0; l < NLVL; l++) begin
            if (in_service_q[l]) begin
                cur_lvl = 2'(l);
            end
        end
        if (in_service_q != '0) begin
            ret_clear[cur_lvl] = 1'b1;
        end
    end

    // Preempt only from strictly higher level
    assign start = (state_q == PIC_IDLE) && i_instr_end && win_ok &&
                   ((in_service_q == '0) || (win_lvl > cur_lvl));
    assign last_call = (state_q == PIC_CALL) && (cnt_q == 3'(CALL_CYCLES - 1));
    // One cycle ahead of the last call cycle, so the registered pulses land inside it (needs two or more call cycles)
    assign ack_next  = (state_q == PIC_CALL) && (cnt_q == 3'(CALL_CYCLES - 2));

    // Forced call sequencer
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state_q <= PIC_IDLE;
            cnt_q   <= 3'h0;
            src_q   <= 4'h0;
            o_level <= 2'h0;
            o_vector <= 16'h0000;
            o_forced_long_call <= 1'b0;
        end else begin
            case (state_q)
                PIC_IDLE: begin
                    if (start) begin
                        state_q  <= PIC_CALL;
                        cnt_q    <= 3'h0;
                        src_q    <= win_src;
                        o_level  <= win_lvl;
                        o_vector <= VEC[win_src];
                        o_forced_long_call <= 1'b1;
                    end
                end
                PIC_CALL: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (last_call) begin
                        state_q <= PIC_IDLE;
                        o_forced_long_call <= 1'b0;
                    end
                end
                default: begin
                    state_q <= PIC_IDLE;
                end
            endcase
        end
    end

    // Taken pulse and acknowledge stand in the last call cycle; markers follow one cycle later
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_vector_taken <= 1'b0;
            o_src_ack      <= '0;
            in_service_q   <= '0;
        end else begin
            o_vector_taken <= ack_next;
            o_src_ack      <= ack_next ? (10'h001 << src_q) : '0;
            in_service_q   <= (in_service_q & ~(i_return_from_interrupt ? ret_clear : '0)) |
                              (last_call ? (4'h1 << o_level) : 4'h0);
        end
    end

    // Event status, set wins over a write-one clear
    assign evt_set = {6'h00, i_return_from_interrupt && (in_service_q != '0), last_call};
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            evt_status_q <= `PIC_RESET_BYTE;
            o_irq        <= 1'b0;
        end else begin
            evt_status_q <= (evt_status_q & ~((wr_en && i_bus.addr == `PIC_ADDR_EVT_STATUS) ?
                            i_bus.wdata : 8'h00)) | evt_set;
            o_irq        <= |(evt_status_q & evt_mask_q);
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                `PIC_ADDR_ENABLE_LO:  o_rdata <= enable_lo_q;
                `PIC_ADDR_ENABLE_HI:  o_rdata <= enable_hi_q;
                `PIC_ADDR_PRIO_LO:    o_rdata <= prio_lo_q;
                `PIC_ADDR_PRIO_HI:    o_rdata <= prio_hi_q;
                `PIC_ADDR_REQ_FLAGS:  o_rdata <= req_flags_q;
                `PIC_ADDR_EVT_STATUS: o_rdata <= evt_status_q;
                `PIC_ADDR_EVT_MASK:   o_rdata <= evt_mask_q;
                default:              o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Checks on the arbitration and call sequence
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    property p_gate;
        start |-> enable_lo_q[`PIC_BIT_GLOBAL_EN] && src_en[win_src];
    endproperty
    a_gate: assert property (p_gate) else $error("source taken while disabled");

    property p_latency;
        start |=> o_forced_long_call [*6] ##0 o_vector_taken;
    endproperty
    a_latency: assert property (p_latency) else $error("forced call not six cycles");

    property p_vector;
        o_vector_taken |-> o_vector == VEC[src_q];
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector");

    property p_preempt;
        start |-> (in_service_q == '0) || (win_lvl > cur_lvl);
    endproperty
    a_preempt: assert property (p_preempt) else $error("preempted by equal or lower level");

    property p_block;
        (state_q == PIC_IDLE) && i_instr_end && win_ok && (in_service_q != '0) && (win_lvl <= cur_lvl) |-> !start;
    endproperty
    a_block: assert property (p_block) else $error("lower request invoked");

    property p_marker;
        o_vector_taken |=> in_service_q[o_level];
    endproperty
    a_marker: assert property (p_marker) else $error("marker not set on vectoring");

    property p_return;
        i_return_from_interrupt && (in_service_q != '0) && !last_call |=>
            $countones(in_service_q) == $countones($past(in_service_q)) - 1;
    endproperty
    a_return: assert property (p_return) else $error("return did not end a level");

    property p_flag_set;
        i_spi_evt |=> req_flags_q[`PIC_BIT_SPI_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event lost");

    property p_t2_keep;
        last_call && src_q == 4'h8 && !(wr_en && i_bus.addr == `PIC_ADDR_REQ_FLAGS) |=>
            req_flags_q[`PIC_BIT_T2_OVF] == $past(req_flags_q[`PIC_BIT_T2_OVF]) || $past(i_tmr2_overflow_evt);
    endproperty
    a_t2_keep: assert property (p_t2_keep) else $error("timer-2 flag cleared by vectoring");

    property p_reload_gate;
        start && win_src == 4'h8 && !$past(req_flags_q[`PIC_BIT_T2_OVF]) |-> $past(enable_hi_q[`PIC_BIT_RELOAD_EN]);
    endproperty
    a_reload_gate: assert property (p_reload_gate) else $error("reload taken while blocked");

    c_nested: cover property (start && in_service_q != '0);
    c_tie: cover property (start && $countones(pending) > 1);
    c_return: cover property (i_return_from_interrupt && in_service_q != '0);
endmodule
`default_nettype wire

// ### bench/pic_core_model.sv
// Behavioural core and level-flag peripherals on the far side of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module pic_core_model (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    // Bench controls
    input  wire logic       i_slow,
    input  wire logic [5:0] i_raise,
    // From the controller
    input  wire logic [9:0] i_src_ack,
    // To the controller
    output logic            o_instr_end,
    output logic [5:0]      o_flags
);
    logic [1:0] phase_q;
    logic [5:0] clr;

    // Ack bits of ext0, tmr0, ext1, tmr1 and both serial flags
    assign clr = {i_src_ack[6], i_src_ack[6], i_src_ack[5], i_src_ack[4], i_src_ack[2], i_src_ack[0]};

    // Flags rise on their condition whatever the enables, and fall only when acknowledged
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_flags <= 6'h00;
        end else begin
            o_flags <= (o_flags & ~clr) | i_raise;
        end
    end

    // A slow core reaches an instruction boundary once in four cycles
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            phase_q     <= 2'h0;
            o_instr_end <= 1'b0;
        end else begin
            phase_q     <= phase_q + 2'h1;
            o_instr_end <= !i_slow || (phase_q == 2'h3);
        end
    end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "pic_map.svh"
module testbench;
    import pic_pkg::*;
    logic        i_ref_clk;
    logic        i_reset;
    logic        slow;
    logic        ret;
    pic_bus_t    bus;
    logic [7:0]  rdata;
    logic [5:0]  raise;
    logic [5:0]  flags;
    logic [5:0]  evt;
    logic        instr_end;
    logic        call;
    logic        taken;
    logic        irq;
    logic [15:0] vec;
    logic [1:0]  lvl;
    logic [9:0]  ack;
    logic [9:0]  ack_s;
    logic [7:0]  exp_c0;
    int          bad_count;
    int          check_count;
    int          takes;
    int          cyc;
    int          n;
    int          t0;
    int          t1;
    logic [7:0]  ra [8] = '{8'hA8, 8'hA9, 8'hB8, 8'hB9, 8'hC0, 8'hC8, 8'hC9, 8'h55};
    logic [7:0]  rm [8] = '{8'hBF, 8'h3F, 8'hB3, 8'h3F, 8'hF3, 8'h00, 8'h03, 8'h00};
    logic [7:0]  hwc [10] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h20};
    logic [7:0]  swc [10] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
    logic [15:0] vt [10] = '{`PIC_VEC_EXT0, `PIC_VEC_PWM, `PIC_VEC_TMR0, `PIC_VEC_SPI, `PIC_VEC_EXT1,
                             `PIC_VEC_TMR1, `PIC_VEC_SER0, `PIC_VEC_LVI, `PIC_VEC_TMR2, `PIC_VEC_TWI};

    // Core model and device under test
    pic_core_model i_core (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_slow(slow), .i_raise(raise),
        .i_src_ack(ack), .o_instr_end(instr_end), .o_flags(flags));
    pic_ctrl #(.CALL_CYCLES(6)) i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
        .i_ext_pin0_flag(flags[0]), .i_tmr0_overflow_flag(flags[1]), .i_ext_pin1_flag(flags[2]),
        .i_tmr1_overflow_flag(flags[3]), .i_serial0_rx_flag(flags[4]), .i_serial0_tx_flag(flags[5]),
        .i_pwm_evt(evt[0]), .i_spi_evt(evt[1]), .i_lowvolt_evt(evt[2]), .i_twowire_evt(evt[3]),
        .i_tmr2_overflow_evt(evt[4]), .i_tmr2_reload_evt(evt[5]), .i_instr_end(instr_end),
        .i_return_from_interrupt(ret), .o_forced_long_call(call), .o_vector(vec), .o_level(lvl),
        .o_vector_taken(taken), .o_src_ack(ack), .o_irq(irq));

    // 10 MHz clock
    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    // Takes counted off the sampling edge; cycle ceiling cuts a hang short
    always @(negedge i_ref_clk) begin
        if (taken === 1'b1) takes++;
    end
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Register bus cycles: one strobe cycle, then an idle cycle
    task wr(input logic [7:0] a, input logic [7:0] v);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge i_ref_clk);
        bus <= '0;
        @(posedge i_ref_clk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input string what);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_ref_clk);
        bus <= '0;
        #1;
        check(what, {8'h00, rdata}, {8'h00, e});
        @(posedge i_ref_clk);
    endtask

    // Peripheral conditions for one cycle, and the core's return
    task fire(input logic [5:0] lv, input logic [5:0] ev);
        raise <= lv;
        evt   <= ev;
        @(posedge i_ref_clk);
        raise <= '0;
        evt   <= '0;
    endtask
    task leave;
        ret <= 1'b1;
        @(posedge i_ref_clk);
        ret <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    // Wait for a vectoring with a bounded count, then compare what it carried
    task take(input logic [15:0] ev, input logic [1:0] el);
        n = 0;
        do begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end while (taken !== 1'b1 && n < 80);
        check("taken", {15'h0000, taken}, 16'h0001);
        check("vector", vec, ev);
        check("level", {14'h0000, lvl}, {14'h0000, el});
        check("call", {15'h0000, call}, 16'h0001);
        ack_s = ack;
        @(posedge i_ref_clk);
    endtask
    task quiet(input int c);
        t0 = takes;
        repeat (c) @(posedge i_ref_clk);
        check("no take", 16'(takes), 16'(t0));
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        i_reset = 1'b1;
        bus = '0;
        raise = '0;
        evt = '0;
        slow = 1'b0;
        ret = 1'b0;
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        @(posedge i_ref_clk);
        // Reset values, writable bits, unmapped place
        for (int i = 0; i < 8; i++) begin
            rd(ra[i], 8'h00, "reset value");
            wr(ra[i], 8'hFF);
            rd(ra[i], rm[i], "write mask");
            wr(ra[i], 8'h00);
        end
        // Global enable low holds off a pending source
        wr(8'hA8, 8'h3F);
        wr(8'hB8, 8'h33);
        fire(6'h00, 6'h01);
        quiet(20);
        rd(8'hC0, 8'h01, "flag while disabled");
        wr(8'hA8, 8'hBF);
        take(`PIC_VEC_PWM, 2'h0);
        wr(8'hC0, 8'h00);
        leave;
        // Fastest response from a level flag
        fire(6'h01, 6'h00);
        take(`PIC_VEC_EXT0, 2'h0);
        check("latency", 16'(n), 16'h0007);
        leave;
        // All ten sources at once on a slow core, served one by one
        slow <= 1'b1;
        t1 = takes;
        fire(6'h3F, 6'h1F);
        exp_c0 = 8'h73;
        for (int k = 0; k < 10; k++) begin
            take(vt[k], 2'h0);
            check("ack", {6'h00, ack_s}, 16'h0001 << k);
            exp_c0 = exp_c0 & ~hwc[k];
            rd(8'hC0, exp_c0, "flags after call");
            exp_c0 = exp_c0 & ~swc[k];
            wr(8'hC0, exp_c0);
            check("one take", 16'(takes), 16'(t1 + k + 1));
            leave;
        end
        // Nesting by level: ext0 level 1, tmr0 level 2, ext1 level 3
        slow <= 1'b0;
        wr(8'hA9, 8'h05);
        wr(8'hB9, 8'h06);
        wr(8'hA8, 8'h87);
        wr(8'hB8, 8'h01);
        fire(6'h01, 6'h00);
        take(`PIC_VEC_EXT0, 2'h1);
        fire(6'h00, 6'h01);
        quiet(20);
        fire(6'h02, 6'h00);
        take(`PIC_VEC_TMR0, 2'h2);
        fire(6'h04, 6'h00);
        take(`PIC_VEC_EXT1, 2'h3);
        leave;
        quiet(15);
        leave;
        quiet(15);
        leave;
        take(`PIC_VEC_PWM, 2'h1);
        wr(8'hC0, 8'h00);
        leave;
        // Timer-2 reload gating, event status, mask and interrupt line
        wr(8'hA8, 8'hA0);
        wr(8'hB8, 8'h00);
        wr(8'hC8, 8'h03);
        fire(6'h00, 6'h20);
        quiet(20);
        rd(8'hC0, 8'h80, "reload flag");
        wr(8'hB8, 8'h80);
        take(`PIC_VEC_TMR2, 2'h0);
        repeat (3) @(posedge i_ref_clk);
        rd(8'hC8, 8'h01, "status taken");
        check("irq masked", {15'h0000, irq}, 16'h0000);
        wr(8'hC9, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        check("irq raised", {15'h0000, irq}, 16'h0001);
        wr(8'hC8, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        check("irq cleared", {15'h0000, irq}, 16'h0000);
        wr(8'hC0, 8'h00);
        leave;
        rd(8'hC8, 8'h02, "status return");
        tally_and_finish();
    end
endmodule
`default_nettype wire
